// File: ipb_pkg.sv
// Shared constants, types and the source map of the priority bank
package ipb_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_REGS = 5;
   localparam int NUM_SRC = 18;
   localparam int REG_W = 16;
   localparam int PRIO_W = 3;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int ADDR_W_DEF = 12;
   localparam int ADDR_W_MIN = 5;

   typedef logic [REG_W-1:0] ipb_word_t;
   typedef logic [PRIO_W-1:0] ipb_level_t;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W_DEF-1:0] OFS_PRIO_CTRL_1 = 12'h000;
   localparam logic [ADDR_W_DEF-1:0] OFS_PRIO_CTRL_2 = 12'h004;
   localparam logic [ADDR_W_DEF-1:0] OFS_PRIO_CTRL_3 = 12'h008;
   localparam logic [ADDR_W_DEF-1:0] OFS_PRIO_CTRL_4 = 12'h00C;
   localparam logic [ADDR_W_DEF-1:0] OFS_PRIO_CTRL_5 = 12'h010;
   localparam logic [ADDR_W_DEF-1:0] REG_OFS [NUM_REGS] = '{
      OFS_PRIO_CTRL_1, OFS_PRIO_CTRL_2, OFS_PRIO_CTRL_3,
      OFS_PRIO_CTRL_4, OFS_PRIO_CTRL_5};

   // ----------------------------------------------------------------
   // Levels and implemented-bit masks
   // ----------------------------------------------------------------
   localparam ipb_level_t LVL_OFF = 3'h0;
   localparam ipb_level_t LVL_MIN = 3'h1;
   localparam ipb_level_t LVL_MAX = 3'h7;
   localparam ipb_level_t LVL_RESET = 3'h4;
   localparam ipb_word_t REG_MASK [NUM_REGS] = '{
      16'h7777, 16'h7777, 16'h0777, 16'h7077, 16'h7777};

   // ----------------------------------------------------------------
   // Source map: index -> register and field low bit
   // ----------------------------------------------------------------
   localparam int SRC_REG [NUM_SRC] = '{
      0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 3, 3, 3, 4, 4, 4, 4};
   localparam int SRC_LSB [NUM_SRC] = '{
      12, 8, 4, 0, 12, 8, 4, 0, 8, 4, 0, 12, 4, 0, 12, 8, 4, 0};

   // ----------------------------------------------------------------
   // Bus carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [STRB_W-1:0] strb;
      logic [DATA_W-1:0] wdata;
   } ipb_apb_req_s;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic ready;
      logic slverr;
   } ipb_apb_rsp_s;

   typedef enum logic [0:0] {
      APB_IDLE = 1'b0,
      APB_ACK = 1'b1
   } ipb_apb_state_e;

endpackage : ipb_pkg

// File: ipb_apb_slave.sv
// APB handshake and registered response of the priority bank
`timescale 1ns/1ps
`default_nettype none
module ipb_apb_slave
   import ipb_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire ipb_apb_req_s req,
   input wire logic addrHit,
   input wire ipb_word_t rdWord,
   output ipb_apb_rsp_s rsp,
   output logic wrStrobe
);

   ipb_apb_state_e state_r;
   ipb_apb_state_e state_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic err_r;
   logic access;
   logic capture;
   logic [DATA_W-1:0] rdImage;

   assign access = req.sel & req.enable;
   assign capture = access & (state_r == APB_IDLE);
   assign rdImage = req.write ? '0 : {{(DATA_W-REG_W){1'b0}}, rdWord};
   // Write lands on the edge that also samples pready high
   assign wrStrobe = access & (state_r == APB_ACK) & req.write &
                     addrHit & clkEn;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         APB_IDLE: begin
            if (capture) begin
               state_nxt = APB_ACK;
            end
         end
         APB_ACK: begin
            state_nxt = APB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= APB_IDLE;
         rdata_r <= '0;
         err_r <= 1'b0;
      end else if (clkEn) begin
         state_r <= state_nxt;
         if (capture) begin
            rdata_r <= rdImage;
            err_r <= ~addrHit;
         end
      end
   end

   assign rsp = '{
      rdata: rdata_r,
      ready: (state_r == APB_ACK),
      slverr: err_r};

endmodule : ipb_apb_slave
`default_nettype wire

// File: ipb_req_gate.sv
// Per-source request gating by level and highest pending level
`timescale 1ns/1ps
`default_nettype none
module ipb_req_gate
   import ipb_pkg::*;
#(
   parameter int N = NUM_SRC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic [N-1:0] srcReq,
   input wire ipb_level_t prio [N],
   output logic [N-1:0] gatedReq_r,
   output ipb_level_t pendLevel_r,
   output logic anyPend_r
);

   logic [N-1:0] gated;
   ipb_level_t lvlChain [N+1];

   assign lvlChain[0] = LVL_OFF;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_src
         // Level zero masks the source completely
         assign gated[i] = srcReq[i] & (prio[i] != LVL_OFF);
         assign lvlChain[i+1] = (gated[i] && (prio[i] > lvlChain[i])) ?
                                prio[i] : lvlChain[i];
         a_disabled_gate: assert property (@(posedge clk)
            disable iff (!reset_n)
            $past(clkEn) && gatedReq_r[i] |-> $past(prio[i]) != LVL_OFF)
            else $error("disabled source passed the gate");
         a_lowest_live: assert property (@(posedge clk)
            disable iff (!reset_n)
            clkEn && srcReq[i] && prio[i] == LVL_MIN |=> gatedReq_r[i])
            else $error("level one source was not passed");
         a_level_top: assert property (@(posedge clk)
            disable iff (!reset_n)
            $past(clkEn) && gatedReq_r[i] |-> pendLevel_r >= $past(prio[i]))
            else $error("pending level below an active source");
      end
   endgenerate

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gatedReq_r <= '0;
         pendLevel_r <= LVL_OFF;
         anyPend_r <= 1'b0;
      end else if (clkEn) begin
         gatedReq_r <= gated;
         pendLevel_r <= lvlChain[N];
         anyPend_r <= |gated;
      end
   end

endmodule : ipb_req_gate
`default_nettype wire

// File: ipb_prio_bank.sv
// Top of the five-register interrupt priority bank with APB access
`timescale 1ns/1ps
`default_nettype none

module ipb_prio_bank
   import ipb_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [STRB_W-1:0] pstrb,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NUM_SRC-1:0] srcReq,
   output logic [NUM_SRC-1:0] gatedReq,
   output logic [PRIO_W-1:0] pendLevel,
   output logic anyPend,
   output logic [PRIO_W-1:0] timerBPriority,
   output logic [PRIO_W-1:0] compareBPriority,
   output logic [PRIO_W-1:0] captureBPriority,
   output logic [PRIO_W-1:0] dmaChADonePriority,
   output logic [PRIO_W-1:0] serialARxPriority,
   output logic [PRIO_W-1:0] syncSerialAEventPriority,
   output logic [PRIO_W-1:0] syncSerialAErrorPriority,
   output logic [PRIO_W-1:0] timerCPriority,
   output logic [PRIO_W-1:0] dmaChBDonePriority,
   output logic [PRIO_W-1:0] adcADonePriority,
   output logic [PRIO_W-1:0] serialATxPriority,
   output logic [PRIO_W-1:0] pinChangePriority,
   output logic [PRIO_W-1:0] twowireAMasterPriority,
   output logic [PRIO_W-1:0] twowireASlavePriority,
   output logic [PRIO_W-1:0] captureHPriority,
   output logic [PRIO_W-1:0] captureGPriority,
   output logic [PRIO_W-1:0] adcBDonePriority,
   output logic [PRIO_W-1:0] extPinBPriority
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   // The offsets need at least five address bits to decode
   if (ADDR_W < ADDR_W_MIN) begin : g_bad_addr_w
      $error("ipb_prio_bank: ADDR_W too narrow for the register map");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   ipb_word_t regQ_r [NUM_REGS];
   ipb_word_t regNxt [NUM_REGS];
   ipb_word_t rdPart [NUM_REGS+1];
   logic [NUM_REGS-1:0] regHit;
   logic anyHit;
   logic aligned;
   ipb_word_t laneMask;
   ipb_word_t rdWord;
   ipb_level_t prioVec [NUM_SRC];
   ipb_apb_req_s apbReq;
   ipb_apb_rsp_s apbRsp;
   logic wrStrobe;
   logic [NUM_SRC-1:0] gatedReq_r;
   ipb_level_t pendLevel_r;
   logic anyPend_r;

   // ----------------------------------------------------------------
   // Address decode and byte lanes
   // ----------------------------------------------------------------
   // Only whole-word aligned addresses hit a register; others error out
   assign aligned = (paddr[1:0] == 2'h0);
   assign anyHit = |regHit;
   // Lanes 2 and 3 carry no storage, so their strobes are don't-care
   assign laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   assign rdPart[0] = '0;
   assign rdWord = rdPart[NUM_REGS];

   assign apbReq = '{
      sel: psel,
      enable: penable,
      write: pwrite,
      strb: pstrb,
      wdata: pwdata};

   // ----------------------------------------------------------------
   // Register storage, one entry per priority register
   // ----------------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < NUM_REGS; k++) begin : g_reg
         assign regHit[k] = aligned &&
            (paddr == ADDR_W'(REG_OFS[k]));
         // Level four in every implemented field; kept a constant so the
         // asynchronous reset branch loads no logic-derived value
         localparam ipb_word_t RESET_WORD = REG_MASK[k] &
            {4{1'b0, LVL_RESET}};
         // Separator bits never store, so they cannot read back one
         assign regNxt[k] = (regQ_r[k] & ~(REG_MASK[k] & laneMask)) |
            (pwdata[REG_W-1:0] & REG_MASK[k] & laneMask);
         assign rdPart[k+1] = rdPart[k] |
            (regHit[k] ? (regQ_r[k] & REG_MASK[k]) : '0);

         always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               regQ_r[k] <= RESET_WORD;
            end else if (wrStrobe && regHit[k]) begin
               regQ_r[k] <= regNxt[k];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Field extraction, one entry per interrupt source
   // ----------------------------------------------------------------
   genvar s;
   generate
      for (s = 0; s < NUM_SRC; s++) begin : g_field
         // Stored code is the level itself, no translation
         assign prioVec[s] =
            regQ_r[SRC_REG[s]][SRC_LSB[s] +: PRIO_W];
      end
   endgenerate

   // Field placement per register follows the source map
   assign timerBPriority = prioVec[0];
   assign compareBPriority = prioVec[1];
   assign captureBPriority = prioVec[2];
   assign dmaChADonePriority = prioVec[3];
   assign serialARxPriority = prioVec[4];
   assign syncSerialAEventPriority = prioVec[5];
   assign syncSerialAErrorPriority = prioVec[6];
   assign timerCPriority = prioVec[7];
   assign dmaChBDonePriority = prioVec[8];
   assign adcADonePriority = prioVec[9];
   assign serialATxPriority = prioVec[10];
   assign pinChangePriority = prioVec[11];
   assign twowireAMasterPriority = prioVec[12];
   assign twowireASlavePriority = prioVec[13];
   assign captureHPriority = prioVec[14];
   assign captureGPriority = prioVec[15];
   assign adcBDonePriority = prioVec[16];
   assign extPinBPriority = prioVec[17];

   // ----------------------------------------------------------------
   // Bus slave and request gate
   // ----------------------------------------------------------------
   ipb_apb_slave u_apb (
      .clk(sys_clk),
      .reset_n(reset_n),
      .clkEn(clk_en),
      .req(apbReq),
      .addrHit(anyHit),
      .rdWord(rdWord),
      .rsp(apbRsp),
      .wrStrobe(wrStrobe)
   );

   ipb_req_gate #(
      .N(NUM_SRC)
   ) u_gate (
      .clk(sys_clk),
      .reset_n(reset_n),
      .clkEn(clk_en),
      .srcReq(srcReq),
      .prio(prioVec),
      .gatedReq_r(gatedReq_r),
      .pendLevel_r(pendLevel_r),
      .anyPend_r(anyPend_r)
   );

   assign prdata = apbRsp.rdata;
   assign pready = apbRsp.ready;
   assign pslverr = apbRsp.slverr;
   assign gatedReq = gatedReq_r;
   assign pendLevel = pendLevel_r;
   assign anyPend = anyPend_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic seenEdge_r;
   ipb_word_t imgWord [NUM_REGS];

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         seenEdge_r <= 1'b0;
      end else if (clk_en) begin
         seenEdge_r <= 1'b1;
      end
   end

   // Register image rebuilt from the field outputs alone
   always_comb begin
      for (int r = 0; r < NUM_REGS; r++) begin
         imgWord[r] = '0;
      end
      for (int j = 0; j < NUM_SRC; j++) begin
         imgWord[SRC_REG[j]][SRC_LSB[j] +: PRIO_W] = prioVec[j];
      end
   end

   sequence s_access_wait;
      psel && penable && !pready && clk_en;
   endsequence

   sequence s_ack_pulse;
      pready ##1 !pready;
   endsequence

   property p_apb_answer;
      @(posedge sys_clk) disable iff (!reset_n)
      s_access_wait |=> s_ack_pulse;
   endproperty

   a_apb_answer: assert property (p_apb_answer)
      else $error("access phase not answered in one cycle");

   a_unmapped_err: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      pready |-> pslverr == !anyHit)
      else $error("error flag does not match decode");

   // One answer per access; a held request would be taken twice
   a_ready_pulse: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      pready && clk_en |=> !pready)
      else $error("ready stayed high for a second cycle");

   // The upper half of the bus word has no storage behind it
   a_upper_zero: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      pready |-> prdata[DATA_W-1:REG_W] == '0)
      else $error("upper read lanes not zero");

   a_write_rdata: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      pready && pwrite |-> prdata == '0)
      else $error("write answered with read data");

   a_miss_rdata: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      pready && !anyHit |-> prdata == '0)
      else $error("unmapped access returned data");

   a_empty_gate: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      !anyPend_r |-> pendLevel_r == LVL_OFF)
      else $error("level shown with nothing pending");

   a_pend_level: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      anyPend_r |-> pendLevel_r >= LVL_MIN)
      else $error("pending request shown at level zero");

   // Frozen cycles must leave the bus answer and the gate untouched
   a_freeze_hold: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      !clk_en |=> $stable(pready) && $stable(gatedReq_r) &&
      $stable(pendLevel_r))
      else $error("state moved while clock enable was low");

   // A write is applied only at the edge that completes it
   sequence s_write_cycle;
      psel && penable && pwrite && !pready && clk_en ##1 pready;
   endsequence

   a_write_strobe: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      s_write_cycle |-> wrStrobe == (anyHit && clk_en))
      else $error("write strobe missing at the answer edge");

   generate
      for (k = 0; k < NUM_REGS; k++) begin : g_chk
         a_reset_level: assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            !seenEdge_r |-> regQ_r[k] == (REG_MASK[k] & 16'h4444))
            else $error("register not at level four after reset");
         a_reserved_zero: assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            (regQ_r[k] & ~REG_MASK[k]) == '0)
            else $error("separator bit holds a one");
         a_write_lands: assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            wrStrobe && regHit[k] && pstrb[1:0] == 2'h3 |=>
            regQ_r[k] == ($past(pwdata[REG_W-1:0]) & REG_MASK[k]))
            else $error("full write did not land");
         // Byte strobes decide which lanes of the stored word may change
         a_lane_keep_hi: assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            wrStrobe && regHit[k] && !pstrb[1] |=>
            regQ_r[k][REG_W-1:8] == $past(regQ_r[k][REG_W-1:8]))
            else $error("upper lane written without its strobe");
         a_lane_keep_lo: assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            wrStrobe && regHit[k] && !pstrb[0] |=>
            regQ_r[k][7:0] == $past(regQ_r[k][7:0]))
            else $error("lower lane written without its strobe");
         a_write_hold: assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            !(wrStrobe && regHit[k]) |=> $stable(regQ_r[k]))
            else $error("register changed without a write");
         a_read_image: assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            pready && !pwrite && regHit[k] |->
            prdata == {{(DATA_W-REG_W){1'b0}}, imgWord[k]})
            else $error("read data differs from field outputs");
      end
   endgenerate

   // Each field output must follow the bits written at its place
   generate
      for (s = 0; s < NUM_SRC; s++) begin : g_src_chk
         a_reset_field: assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            !seenEdge_r |-> prioVec[s] == LVL_RESET)
            else $error("field not at level four after reset");
         a_field_follows: assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            wrStrobe && regHit[SRC_REG[s]] && pstrb[1:0] == 2'h3 |=>
            prioVec[s] == $past(pwdata[SRC_LSB[s] +: PRIO_W]))
            else $error("field output does not follow its write");
      end
   endgenerate

endmodule : ipb_prio_bank
`default_nettype wire

// File: ipb_dummy_guard.sv
// Intentionally empty compile unit kept out of the design
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: ipb_src_model.sv
// Behavioural model of the peripheral request sources
`timescale 1ns/1ps
`default_nettype none
module ipb_src_model
   import ipb_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [NUM_SRC-1:0] pattern,
   output logic [NUM_SRC-1:0] srcReq
);
   // ----------------------------------------------------------------
   // Request levels
   // ----------------------------------------------------------------
   // Launched from a flop, as a peripheral would, so edges never race
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         srcReq <= '0;
      end else begin
         srcReq <= pattern;
      end
   end
endmodule : ipb_src_model
`default_nettype wire

// File: tb_top.sv
// Self-checking bench of the priority bank against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ipb_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic sys_clk, reset_n, psel, penable, pwrite;
   logic [ADDR_W_DEF-1:0] paddr;
   logic [DATA_W-1:0] pwdata, rd, rnd;
   logic [STRB_W-1:0] pstrb, strb;
   logic [NUM_SRC-1:0] pattern;
   logic er, clkEn;
   wire logic [DATA_W-1:0] prdata;
   wire logic pready, pslverr, anyPend;
   wire logic [NUM_SRC-1:0] srcReq, gatedReq;
   wire logic [PRIO_W-1:0] pendLevel;
   wire logic [PRIO_W-1:0] prio [NUM_SRC];
   logic [ADDR_W_DEF-1:0] bad [3] = '{12'h014, 12'h002, 12'hFFC};
   int mdl [NUM_REGS];
   int errors = 0, totalChecks = 0, cycles = 0, seed, r;

   ipb_prio_bank DUT (.sys_clk(sys_clk), .reset_n(reset_n),
      .clk_en(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .srcReq(srcReq),
      .gatedReq(gatedReq), .pendLevel(pendLevel), .anyPend(anyPend),
      .timerBPriority(prio[0]), .compareBPriority(prio[1]),
      .captureBPriority(prio[2]), .dmaChADonePriority(prio[3]),
      .serialARxPriority(prio[4]), .syncSerialAEventPriority(prio[5]),
      .syncSerialAErrorPriority(prio[6]), .timerCPriority(prio[7]),
      .dmaChBDonePriority(prio[8]), .adcADonePriority(prio[9]),
      .serialATxPriority(prio[10]), .pinChangePriority(prio[11]),
      .twowireAMasterPriority(prio[12]),
      .twowireASlavePriority(prio[13]), .captureHPriority(prio[14]),
      .captureGPriority(prio[15]), .adcBDonePriority(prio[16]),
      .extPinBPriority(prio[17]));

   ipb_src_model SRC (.clk(sys_clk), .reset_n(reset_n),
      .pattern(pattern), .srcReq(srcReq));

   // ----------------------------------------------------------------
   // Clock and hang guard
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Whole run needs about 1200 cycles; the guard leaves ample margin
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         final_report();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
      totalChecks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t %s: seen %h expected %h", $time, what,
            seen, exp);
      end
   endtask : check

   // Entered just after a rising edge; leaves one idle edge behind it
   task automatic apb(input logic w, input logic [ADDR_W_DEF-1:0] a,
      input logic [DATA_W-1:0] d, input logic [STRB_W-1:0] s,
      output logic [DATA_W-1:0] q, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1);
      check(n, 2, "answer delay");
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   task automatic wr(input int i, input logic [DATA_W-1:0] d,
      input logic [STRB_W-1:0] s);
      logic [DATA_W-1:0] q;
      logic e;
      int v;
      apb(1'b1, REG_OFS[i], d, s, q, e);
      check(e, 1'b0, "write error");
      v = mdl[i];
      if (s[0]) v[7:0] = d[7:0];
      if (s[1]) v[15:8] = d[15:8];
      mdl[i] = v & REG_MASK[i];
   endtask : wr

   task automatic check_all();
      logic [DATA_W-1:0] q;
      logic e;
      logic [NUM_SRC-1:0] expG;
      int lvl, maxLvl;
      maxLvl = 0;
      for (int i = 0; i < NUM_REGS; i++) begin
         apb(1'b0, REG_OFS[i], 32'h0, 4'hF, q, e);
         check(q, mdl[i], "read back");
         check(e, 1'b0, "read error");
      end
      for (int i = 0; i < NUM_SRC; i++) begin
         lvl = (mdl[SRC_REG[i]] >> SRC_LSB[i]) & 32'h7;
         check(prio[i], lvl, "field");
         expG[i] = pattern[i] && lvl != 0;
         if (expG[i] && lvl > maxLvl) maxLvl = lvl;
      end
      check(gatedReq, expG, "gated");
      check(pendLevel, maxLvl, "level");
      check(anyPend, |expG, "pending");
   endtask : check_all

   task automatic reset_model();
      for (int i = 0; i < NUM_REGS; i++) begin
         mdl[i] = 32'h4444 & REG_MASK[i];
      end
   endtask : reset_model

   task automatic final_report();
      if (errors == 0 && totalChecks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 70;
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      pattern = '1;
      clkEn = 1'b1;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      reset_model();
      check_all();
      for (int i = 0; i < NUM_REGS; i++) wr(i, 32'hFFFFFFFF, 4'hF);
      check_all();
      for (int i = 0; i < NUM_REGS; i++) wr(i, 32'h0, 4'hF);
      check_all();
      // Top level, lowest level and off side by side
      wr(0, 32'h7100, 4'hF);
      wr(1, 32'h0001, 4'hF);
      check_all();
      // Refused places leave every register untouched
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, bad[i], 32'hFFFFFFFF, 4'hF, rd, er);
         check(er, 1'b1, "bad write flag");
         apb(1'b0, bad[i], 32'h0, 4'hF, rd, er);
         check(er, 1'b1, "bad read flag");
         check(rd, 32'h0, "bad read data");
      end
      check_all();
      repeat (40) begin
         r = {$random(seed)} % NUM_REGS;
         rnd = $random(seed);
         pattern <= rnd[NUM_SRC-1:0];
         rnd = $random(seed);
         strb = (rnd[1:0] == 2'h0) ? rnd[7:4] : 4'hF;
         wr(r, $random(seed), strb);
         check_all();
      end
      // Frozen cycles hold the gated requests whatever the sources do
      rd = gatedReq;
      clkEn <= 1'b0;
      pattern <= ~pattern;
      repeat (4) @(posedge sys_clk);
      check(gatedReq, rd, "frozen gate");
      clkEn <= 1'b1;
      check_all();
      // A second reset in mid-run restores the defaults
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      reset_model();
      check_all();
      final_report();
   end
endmodule : tb_top
`default_nettype wire
